// ===== pkg/act_pkg.sv
// constants, field layouts and carrier types for the activity clock throttle
package act_pkg;

    // ***************************************************
    // clock and sampling periods
    // ***************************************************
    localparam int unsigned ACT_CLK_NS = 5;
    // sampling periods in ns, rate codes 0 to 7
    localparam int unsigned ACT_RATE_NS [8] = '{61000, 122000, 244000, 488000,
        976000, 1950000, 3910000, 7810000};
    localparam int unsigned ACT_RATE_CYC [8] = '{
        ACT_RATE_NS[0] / ACT_CLK_NS, ACT_RATE_NS[1] / ACT_CLK_NS,
        ACT_RATE_NS[2] / ACT_CLK_NS, ACT_RATE_NS[3] / ACT_CLK_NS,
        ACT_RATE_NS[4] / ACT_CLK_NS, ACT_RATE_NS[5] / ACT_CLK_NS,
        ACT_RATE_NS[6] / ACT_CLK_NS, ACT_RATE_NS[7] / ACT_CLK_NS};
    localparam int ACT_CNT_W = 21;

    // ***************************************************
    // register indices, byte address is four times index
    // ***************************************************
    localparam int ACT_ADDR_W = 12;
    localparam logic [7:0] ACT_IDX_IDLE_STEP = 8'hE0;
    localparam logic [7:0] ACT_IDX_BUSY_STEP = 8'hE1;
    localparam logic [7:0] ACT_IDX_LEVEL = 8'hE2;
    localparam logic [7:0] ACT_IDX_CONTROL = 8'hE3;
    localparam logic [7:0] ACT_IDX_MASK = 8'hF0;
    localparam logic [7:0] ACT_IDX_STATUS = 8'hF1;

    // ***************************************************
    // reset values and field positions
    // ***************************************************
    localparam logic [7:0] ACT_RST_IDLE_STEP = 8'h00;
    localparam logic [7:0] ACT_RST_BUSY_STEP = 8'h00;
    localparam logic [7:0] ACT_RST_LEVEL = 8'hFF;
    localparam logic [7:0] ACT_LEVEL_FULL = 8'hFF;
    localparam logic [7:0] ACT_LEVEL_ZERO = 8'h00;
    localparam logic ACT_RST_ENABLE = 1'b0;
    localparam logic [2:0] ACT_RST_RATE = 3'h0;
    localparam logic ACT_RST_CS_MASK = 1'b1;
    localparam logic ACT_RST_KBD_MASK = 1'b1;
    localparam int ACT_CTRL_EN_BIT = 7;
    localparam int ACT_CTRL_RATE_LSB = 0;
    localparam int ACT_MASK_CS_BIT = 0;
    localparam int ACT_MASK_KBD_BIT = 1;
    localparam int ACT_STAT_REQ_BIT = 0;
    localparam logic [1:0] ACT_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACT_RESP_SLVERR = 2'h2;

    // ***************************************************
    // carrier types
    // ***************************************************
    typedef struct packed {
        logic enable;
        logic [2:0] rate;
    } act_ctrl_t;

    typedef struct packed {
        logic kbd;
        logic cs;
    } act_mask_t;

    typedef enum logic [0:0] {
        ACT_WR_IDLE = 1'b0,
        ACT_WR_RESP = 1'b1
    } act_wr_state_t;

endpackage : act_pkg

// ===== rtl/act_throttle.sv
// activity driven processor clock throttle with axi4-lite registers
// Behaviour
// - chip select mask bit, reset 1; cleared lets chip select activity count
// - idle step is 8-bit two's complement, reset zero, up to +127
// - busy period end adds unsigned busy step (reset zero) to level
// - 8-bit activity level tracks unmasked sources, resets to all ones
// - level at zero raises the slow/stop request
// - request stays raised until level reaches all ones
// - after all ones, no new request until level returns to zero
// - control bit 7 enables sampling, reset 0; level writable while 0
// - 3-bit rate selects period 61us to 7.81ms, reset code 0
// - keyboard mask bit, reset 1; cleared lets keyboard accesses count
`timescale 1ns/1ps
`default_nettype none

module act_throttle #(
    parameter int unsigned RATE_CYC [8] = act_pkg::ACT_RATE_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [act_pkg::ACT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [act_pkg::ACT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic chip_select_activity,
    input wire logic keyboard_activity,
    output logic slow_stop_request
);
    import act_pkg::*;

    // ***************************************************
    // activity input synchronisers
    // ***************************************************
    logic [1:0] sync_a;
    logic [1:0] sync_b;

    // pins are asynchronous, two flops before any use
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
        end else begin
            sync_a <= {keyboard_activity, chip_select_activity};
            sync_b <= sync_a;
        end
    end

    // ***************************************************
    // register state
    // ***************************************************
    logic [7:0] idle_step_value;
    logic [7:0] busy_step_value;
    logic [7:0] activity_level_count;
    act_ctrl_t ctrl;
    act_mask_t mask;
    logic [7:0] next_idle_step_value;
    logic [7:0] next_busy_step_value;
    logic [7:0] next_activity_level_count;
    act_ctrl_t next_ctrl;
    act_mask_t next_mask;
    logic throttle_sampling_enable;
    logic [2:0] sampling_rate_select;
    logic chip_select_activity_mask;
    logic keyboard_activity_mask;

    assign throttle_sampling_enable = ctrl.enable;
    assign sampling_rate_select = ctrl.rate;
    assign chip_select_activity_mask = mask.cs;
    assign keyboard_activity_mask = mask.kbd;

    // ***************************************************
    // axi4-lite write channel
    // ***************************************************
    act_wr_state_t wr_st;
    act_wr_state_t next_wr_st;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [1:0] bresp;
    logic next_aw_full;
    logic next_w_full;
    logic [7:0] next_aw_idx;
    logic [7:0] next_w_byte;
    logic next_w_lane0;
    logic [1:0] next_bresp;
    logic do_write;
    logic wr_hit;

    // address and data taken in either order, held until both arrive
    assign s_axi_awready = !aw_full && (wr_st == ACT_WR_IDLE);
    assign s_axi_wready = !w_full && (wr_st == ACT_WR_IDLE);
    assign s_axi_bvalid = (wr_st == ACT_WR_RESP);
    assign s_axi_bresp = bresp;
    assign do_write = aw_full && w_full && (wr_st == ACT_WR_IDLE);

    // write bookkeeping and response state
    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_idx = aw_idx;
        next_w_byte = w_byte;
        next_w_lane0 = w_lane0;
        next_bresp = bresp;
        next_wr_st = wr_st;
        wr_hit = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_idx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_byte = s_axi_wdata[7:0];
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (aw_idx == ACT_IDX_IDLE_STEP || aw_idx == ACT_IDX_BUSY_STEP) begin
            wr_hit = 1'b1;
        end else if (aw_idx == ACT_IDX_LEVEL || aw_idx == ACT_IDX_CONTROL) begin
            wr_hit = 1'b1;
        end else if (aw_idx == ACT_IDX_MASK || aw_idx == ACT_IDX_STATUS) begin
            wr_hit = 1'b1;
        end
        case (wr_st)
            ACT_WR_IDLE: begin
                if (do_write) begin
                    next_aw_full = 1'b0;
                    next_w_full = 1'b0;
                    next_bresp = wr_hit ? ACT_RESP_OKAY : ACT_RESP_SLVERR;
                    next_wr_st = ACT_WR_RESP;
                end
            end
            ACT_WR_RESP: begin
                if (s_axi_bready) begin
                    next_wr_st = ACT_WR_IDLE;
                end
            end
            default: next_wr_st = ACT_WR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_idx <= 8'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            bresp <= ACT_RESP_OKAY;
            wr_st <= ACT_WR_IDLE;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_idx <= next_aw_idx;
            w_byte <= next_w_byte;
            w_lane0 <= next_w_lane0;
            bresp <= next_bresp;
            wr_st <= next_wr_st;
        end
    end

    // ***************************************************
    // sampling period counter and activity capture
    // ***************************************************
    logic [ACT_CNT_W-1:0] period_cnt;
    logic [ACT_CNT_W-1:0] next_period_cnt;
    logic [ACT_CNT_W-1:0] period_last;
    logic period_end;
    logic seen;
    logic next_seen;
    logic act_now;

    // unmasked activity this cycle
    assign act_now = (sync_b[0] && !chip_select_activity_mask)
        || (sync_b[1] && !keyboard_activity_mask);
    assign period_last = ACT_CNT_W'(RATE_CYC[sampling_rate_select] - 1);
    assign period_end = throttle_sampling_enable && (period_cnt >= period_last);

    // a rate change to a period the count has already passed ends it at once rather than overrunning
    always_comb begin
        next_period_cnt = period_cnt;
        next_seen = seen;
        if (!ctrl.enable) begin
            next_period_cnt = '0;
            next_seen = 1'b0;
        end else if (period_end) begin
            next_period_cnt = '0;
            next_seen = 1'b0;
        end else begin
            next_period_cnt = period_cnt + 1'b1;
            next_seen = seen || act_now;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            period_cnt <= '0;
            seen <= 1'b0;
        end else begin
            period_cnt <= next_period_cnt;
            seen <= next_seen;
        end
    end

    // ***************************************************
    // level update and software registers
    // ***************************************************
    logic signed [9:0] step;
    logic signed [9:0] sum;
    logic [7:0] updated_level;
    logic busy_period;

    // activity in the final cycle still counts for this period
    assign busy_period = seen || act_now;

    // widen to ten bits so the sum can be clamped, not wrapped
    always_comb begin
        if (busy_period) begin
            step = {2'b00, busy_step_value};
        end else begin
            step = {{2{idle_step_value[7]}}, idle_step_value};
        end
        sum = $signed({2'b00, activity_level_count}) + step;
        if (sum < 0) begin
            updated_level = ACT_LEVEL_ZERO;
        end else if (sum > $signed({2'b00, ACT_LEVEL_FULL})) begin
            updated_level = ACT_LEVEL_FULL;
        end else begin
            updated_level = sum[7:0];
        end
    end

    // software writes and periodic level update
    always_comb begin
        next_idle_step_value = idle_step_value;
        next_busy_step_value = busy_step_value;
        next_activity_level_count = activity_level_count;
        next_ctrl = ctrl;
        next_mask = mask;
        if (period_end) begin
            next_activity_level_count = updated_level;
        end
        if (do_write && w_lane0) begin
            if (aw_idx == ACT_IDX_IDLE_STEP) begin
                next_idle_step_value = w_byte;
            end else if (aw_idx == ACT_IDX_BUSY_STEP) begin
                next_busy_step_value = w_byte;
            end else if (aw_idx == ACT_IDX_LEVEL) begin
                // ignored while sampling runs, so preload needs a pause
                if (!ctrl.enable) begin
                    next_activity_level_count = w_byte;
                end
            end else if (aw_idx == ACT_IDX_CONTROL) begin
                next_ctrl.enable = w_byte[ACT_CTRL_EN_BIT];
                next_ctrl.rate = w_byte[ACT_CTRL_RATE_LSB +: 3];
            end else if (aw_idx == ACT_IDX_MASK) begin
                next_mask.cs = w_byte[ACT_MASK_CS_BIT];
                next_mask.kbd = w_byte[ACT_MASK_KBD_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            idle_step_value <= ACT_RST_IDLE_STEP;
            busy_step_value <= ACT_RST_BUSY_STEP;
            activity_level_count <= ACT_RST_LEVEL;
            ctrl <= '{enable: ACT_RST_ENABLE, rate: ACT_RST_RATE};
            mask <= '{kbd: ACT_RST_KBD_MASK, cs: ACT_RST_CS_MASK};
        end else begin
            idle_step_value <= next_idle_step_value;
            busy_step_value <= next_busy_step_value;
            activity_level_count <= next_activity_level_count;
            ctrl <= next_ctrl;
            mask <= next_mask;
        end
    end

    // ***************************************************
    // slow/stop request with hysteresis
    // ***************************************************
    logic next_request;

    always_comb begin
        next_request = slow_stop_request;
        if (activity_level_count == ACT_LEVEL_ZERO) begin
            next_request = 1'b1;
        end else if (activity_level_count == ACT_LEVEL_FULL) begin
            next_request = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            slow_stop_request <= 1'b0;
        end else begin
            slow_stop_request <= next_request;
        end
    end

    // ***************************************************
    // axi4-lite read channel
    // ***************************************************
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [7:0] ar_idx;

    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign ar_idx = s_axi_araddr[9:2];

    // one read at a time; data stays until rready
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rdata = 32'h0000_0000;
            next_rresp = ACT_RESP_OKAY;
            if (ar_idx == ACT_IDX_IDLE_STEP) begin
                next_rdata[7:0] = idle_step_value;
            end else if (ar_idx == ACT_IDX_BUSY_STEP) begin
                next_rdata[7:0] = busy_step_value;
            end else if (ar_idx == ACT_IDX_LEVEL) begin
                next_rdata[7:0] = activity_level_count;
            end else if (ar_idx == ACT_IDX_CONTROL) begin
                next_rdata[ACT_CTRL_EN_BIT] = ctrl.enable;
                next_rdata[ACT_CTRL_RATE_LSB +: 3] = ctrl.rate;
            end else if (ar_idx == ACT_IDX_MASK) begin
                next_rdata[ACT_MASK_CS_BIT] = mask.cs;
                next_rdata[ACT_MASK_KBD_BIT] = mask.kbd;
            end else if (ar_idx == ACT_IDX_STATUS) begin
                next_rdata[ACT_STAT_REQ_BIT] = slow_stop_request;
            end else begin
                next_rresp = ACT_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= ACT_RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // ***************************************************
    // assertions
    // ***************************************************
    a_req_at_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
        activity_level_count == ACT_LEVEL_ZERO |=> slow_stop_request)
        else $error("request not raised at zero level");
    a_req_hold_mid: assert property (@(posedge ref_clk) disable iff (!reset_n)
        slow_stop_request && activity_level_count != ACT_LEVEL_FULL |=> slow_stop_request)
        else $error("request dropped before full level");
    a_req_drop_full: assert property (@(posedge ref_clk) disable iff (!reset_n)
        activity_level_count == ACT_LEVEL_FULL |=> !slow_stop_request)
        else $error("request held at full level");
    a_no_new_req: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !slow_stop_request && activity_level_count != ACT_LEVEL_ZERO |=> !slow_stop_request)
        else $error("request raised above zero");
    a_level_paused: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !ctrl.enable && !(do_write && aw_idx == ACT_IDX_LEVEL) |=> $stable(activity_level_count))
        else $error("level moved while paused");
    a_busy_step_add: assert property (@(posedge ref_clk) disable iff (!reset_n)
        period_end && busy_period && !do_write && activity_level_count <= 8'h7F
        && busy_step_value <= 8'h7F
        |=> activity_level_count == $past(activity_level_count) + $past(busy_step_value))
        else $error("busy step not added");
    a_idle_clamp: assert property (@(posedge ref_clk) disable iff (!reset_n)
        period_end && !busy_period && idle_step_value[7] && !do_write
        && activity_level_count < (~idle_step_value + 8'h01)
        |=> activity_level_count == ACT_LEVEL_ZERO)
        else $error("idle step did not clamp at zero");
    a_mask_reset: assert property (@(posedge ref_clk)
        !reset_n |=> mask.cs && mask.kbd && idle_step_value == ACT_RST_IDLE_STEP)
        else $error("mask or idle step reset wrong");
    a_period_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
        period_end |-> period_cnt == period_last)
        else $error("period ended off count");

endmodule : act_throttle

`default_nettype wire

// ===== test/act_clock_manager.sv
// behavioural clock slow/stop manager facing the activity throttle
`timescale 1ns/1ps
`default_nettype none

module act_clock_manager (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cs_on,
    input wire logic kbd_on,
    input wire logic slow_stop_request,
    output logic chip_select_activity,
    output logic keyboard_activity,
    output logic [7:0] request_count
);
    logic [1:0] phase;
    logic last_req;

    // ***************************************************
    // activity pulses and request counting
    // ***************************************************
    // single-cycle pulses, not levels, so the throttle must capture them
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            phase <= 2'h0;
            last_req <= 1'b0;
            request_count <= 8'h00;
        end else begin
            phase <= phase + 2'h1;
            last_req <= slow_stop_request;
            if (slow_stop_request && !last_req) begin
                request_count <= request_count + 8'h01;
            end
        end
    end
    // the two sources never pulse together
    assign chip_select_activity = cs_on && (phase == 2'h1);
    assign keyboard_activity = kbd_on && (phase == 2'h2);
endmodule : act_clock_manager

`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the activity clock throttle
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import act_pkg::*;
    // short periods keep the run brief; expectations derive from them
    localparam int unsigned SIM_CYC [8] = '{8, 16, 24, 32, 40, 48, 56, 64};
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic cs_on = 1'b0;
    logic kbd_on = 1'b0;
    wire logic awready, wready, bvalid, arready, rvalid, cs_act, kbd_act, req;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] req_count;
    int num_errors = 0;
    int tests_run = 0;

    always #2.5 ref_clk = ~ref_clk;

    act_throttle #(.RATE_CYC(SIM_CYC)) act_throttle_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .chip_select_activity(cs_act), .keyboard_activity(kbd_act),
        .slow_stop_request(req));

    act_clock_manager act_clock_manager_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .cs_on(cs_on), .kbd_on(kbd_on), .slow_stop_request(req),
        .chip_select_activity(cs_act), .keyboard_activity(kbd_act),
        .request_count(req_count));

    // ***************************************************
    // shared tasks
    // ***************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
        int n;
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk);
        awaddr <= {2'h0, idx, 2'h0};
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 100) check("write answer", 32'h0, 32'h1);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic ar_done;
        ar_done = 1'b0;
        @(posedge ref_clk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (!ar_done && arready) begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 100) check("read answer", 32'h0, 32'h1);
    endtask : rd

    task automatic wr_ok(input logic [7:0] idx, input logic [7:0] d);
        logic [1:0] r;
        wr(idx, d, r);
        check("write resp", {30'h0, r}, {30'h0, ACT_RESP_OKAY});
    endtask : wr_ok

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        check(name, d, {24'h000000, exp});
    endtask : rd_chk

    // bounded wait for the request pin to reach a level
    task automatic wait_req(input logic lvl, input int limit);
        int n;
        for (n = 0; n < limit && req !== lvl; n++) @(posedge ref_clk);
        check("request level", {31'h0, req}, {31'h0, lvl});
    endtask : wait_req

    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic s_reset_values;
        logic [31:0] d;
        logic [1:0] r;
        rd_chk("idle step", ACT_IDX_IDLE_STEP, 8'h00);
        rd_chk("busy step", ACT_IDX_BUSY_STEP, 8'h00);
        rd_chk("level", ACT_IDX_LEVEL, 8'hFF);
        rd_chk("control", ACT_IDX_CONTROL, 8'h00);
        rd_chk("mask", ACT_IDX_MASK, 8'h03);
        rd_chk("status", ACT_IDX_STATUS, 8'h00);
        rd(8'h00, d, r);
        check("unmapped data", d, 32'h00000000);
        check("unmapped rresp", {30'h0, r}, {30'h0, ACT_RESP_SLVERR});
        wr(8'h07, 8'h5A, r);
        check("unmapped bresp", {30'h0, r}, {30'h0, ACT_RESP_SLVERR});
    endtask : s_reset_values

    // -128 idle step drops FF to 7F then clamps at zero
    task automatic s_fall_to_zero;
        wr_ok(ACT_IDX_IDLE_STEP, 8'h80);
        wr_ok(ACT_IDX_BUSY_STEP, 8'h40);
        wr_ok(ACT_IDX_CONTROL, 8'h80);
        wait_req(1'b1, 60);
        rd_chk("level floor", ACT_IDX_LEVEL, 8'h00);
        rd_chk("status set", ACT_IDX_STATUS, 8'h01);
    endtask : s_fall_to_zero

    // request holds while the level climbs, drops only at FF
    task automatic s_hysteresis;
        cs_on <= 1'b1;
        wr_ok(ACT_IDX_MASK, 8'h02);
        repeat (20) @(posedge ref_clk);
        check("request held", {31'h0, req}, 32'h1);
        wait_req(1'b0, 80);
        rd_chk("level ceiling", ACT_IDX_LEVEL, 8'hFF);
        check("request count", {24'h0, req_count}, 32'h1);
        cs_on <= 1'b0;
        wr_ok(ACT_IDX_IDLE_STEP, 8'hFF);
        repeat (40) @(posedge ref_clk);
        check("no new request", {31'h0, req}, 32'h0);
    endtask : s_hysteresis

    // each rate code: preload, run four periods of -1, pause, read back
    task automatic s_rates;
        for (int i = 0; i < 8; i++) begin
            wr_ok(ACT_IDX_CONTROL, 8'h00);
            wr_ok(ACT_IDX_LEVEL, 8'h10);
            rd_chk("preload", ACT_IDX_LEVEL, 8'h10);
            wr_ok(ACT_IDX_CONTROL, 8'h80 | 8'(i));
            // enable lands an edge before the wait, the pause three after it
            repeat (SIM_CYC[i] * 4 + SIM_CYC[i] / 2 - 4) @(posedge ref_clk);
            wr_ok(ACT_IDX_CONTROL, 8'h00);
            rd_chk("rate periods", ACT_IDX_LEVEL, 8'h0C);
        end
    endtask : s_rates

    // level write refused while enabled; masks gate each source
    task automatic s_masks;
        logic [31:0] d;
        logic [1:0] r;
        wr_ok(ACT_IDX_IDLE_STEP, 8'h00);
        wr_ok(ACT_IDX_BUSY_STEP, 8'h10);
        wr_ok(ACT_IDX_MASK, 8'h03);
        wr_ok(ACT_IDX_CONTROL, 8'h80);
        wr_ok(ACT_IDX_LEVEL, 8'h55);
        rd_chk("level locked", ACT_IDX_LEVEL, 8'h0C);
        cs_on <= 1'b1;
        kbd_on <= 1'b1;
        repeat (40) @(posedge ref_clk);
        rd_chk("masked sources", ACT_IDX_LEVEL, 8'h0C);
        wr_ok(ACT_IDX_MASK, 8'h01);
        cs_on <= 1'b0;
        repeat (40) @(posedge ref_clk);
        wr_ok(ACT_IDX_CONTROL, 8'h00);
        rd(ACT_IDX_LEVEL, d, r);
        check("keyboard counts", {31'h0, d > 32'h0C}, 32'h1);
        check("level step size", {28'h0, d[3:0]}, 32'hC);
        kbd_on <= 1'b0;
    endtask : s_masks

    // ***************************************************
    // run control
    // ***************************************************
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // whole sequence needs about 1700 cycles
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        s_reset_values();
        s_fall_to_zero();
        s_hysteresis();
        s_rates();
        s_masks();
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
